// >>> core/icpc_pkg.sv
// Shared constants and carrier types for the isolated channel pulse codec
package icpc_pkg;

  // Reference clock period, 8 ns at 125 MHz
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_0008;

  // Edge pulse width, about 1 ns
  localparam int unsigned PULSE_NS      = 32'h0000_0001;
  // Input idle time before refresh starts, 1000 ns
  localparam int unsigned REFRESH_NS    = 32'h0000_03E8;
  // Silence on the receive side before the watchdog fires, 5000 ns
  localparam int unsigned WDOG_NS       = 32'h0000_1388;

  // Pulse is a longest time: round down, but never below one cycle
  localparam int unsigned PULSE_CYC   = (PULSE_NS / CLK_PERIOD_NS > 0) ?
                                        PULSE_NS / CLK_PERIOD_NS : 32'h0000_0001;
  // Refresh waits more than its time: round up
  localparam int unsigned REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Watchdog is a longest silence: round down
  localparam int unsigned WDOG_CYC    = WDOG_NS / CLK_PERIOD_NS;

  // Junction thresholds behind the two thermal indications, in degrees C
  localparam int unsigned THERM_OFF_C = 32'h0000_0096;
  localparam int unsigned THERM_ON_C  = 32'h0000_0082;

  // Synchroniser bit positions
  localparam int unsigned SYNC_LOCK = 32'h0000_0000;
  localparam int unsigned SYNC_HOT  = 32'h0000_0001;
  localparam int unsigned SYNC_COOL = 32'h0000_0002;
  localparam int unsigned SYNC_W    = 32'h0000_0003;

  // Synchroniser reset: held in lockout, thermally normal
  localparam logic [2:0] SYNC_RST = 3'h1;

  // Default output level
  localparam logic LEVEL_DEFAULT = 1'h0;

  // Polarity-coded pulse across the barrier
  typedef struct packed {
    logic set;
    logic clr;
  } icpc_pulse_t;

  // Tri-state data output pad
  typedef struct packed {
    logic level;
    logic oe;
  } icpc_pad_t;

endpackage

// >>> core/icpc_channel.sv
// One isolation channel half: edge/refresh encoder, bistable decoder, power gating
//
// Operation
// R1 - Each input edge sends one short pulse, set for rising, clear for falling.
// R2 - Decoder is bistable: set pulse drives high, clear pulse drives low, holds.
// R3 - Input idle over 1 us sends periodic refresh pulses of current level.
// R4 - No received pulse for about 5 us forces output to default level.
// R5 - Over-temperature above 150 C turns converter PWM drive off.
// R6 - PWM drive resumes only after temperature indication drops below 130 C.
// R7 - Under lockout the converter oscillator is held inactive.
// R8 - Under lockout drivers and refresh generator stay idle, sending no pulses.
// R9 - Under lockout the data output is high impedance.
// R10 - Logic stays idle after power-up until lockout releases.
// R11 - Leaving lockout, output drives low until first valid pulse arrives.
// R12 - Output follows far input within 1 us after lockout release.
// R13 - Far side lost: output holds last level until watchdog or lockout.
// R14 - Refresh and watchdog intervals count reference clock cycles, parameterised.
// R15 - Lockout and thermal indications pass a two-stage synchroniser.
`timescale 1ns/1ps

module icpc_channel
  import icpc_pkg::*;
#(
  parameter int unsigned PULSE_LEN   = PULSE_CYC,
  parameter int unsigned REFRESH_LEN = REFRESH_CYC,
  parameter int unsigned WDOG_LEN    = WDOG_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Asynchronous supply and thermal indications
  input  wire logic        undervoltage_lockout_i,
  input  wire logic        temp_over_hi_i,
  input  wire logic        temp_under_lo_i,
  // Local data input and encoded pulses to the far side
  input  wire logic        data_i,
  output icpc_pulse_t      tx_pulse_o,
  // Pulses from the far side and decoded output pad
  input  wire icpc_pulse_t rx_pulse_i,
  output icpc_pad_t        pad_o,
  // Converter control
  output logic             osc_en_o,
  output logic             pwm_en_o
);

  localparam int unsigned PW = $clog2(PULSE_LEN + 1);
  localparam int unsigned RW = $clog2(REFRESH_LEN + 1);
  localparam int unsigned WW = $clog2(WDOG_LEN + 1);

  // Synchroniser stages
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] async_in;
  logic              lock_s;
  logic              hot_s;
  logic              cool_s;

  // Transmit state
  logic              sent_level_reg;
  logic [RW-1:0]     idle_cnt_reg;
  logic [PW-1:0]     pw_cnt_reg;
  icpc_pulse_t       tx_pulse_reg;
  logic              tx_edge;
  logic              tx_due;
  logic              tx_start;

  // Receive state
  logic              dec_reg;
  logic              oe_reg;
  logic [WW-1:0]     wd_cnt_reg;
  logic              rx_valid;
  logic              wd_expired;

  // Power control state
  logic              pwm_off_reg;
  logic              pwm_off_next;
  logic              osc_en_reg;
  logic              pwm_en_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Input synchronisers

  // Gather the asynchronous indications in synchroniser order
  always_comb begin
    async_in            = '0;
    async_in[SYNC_LOCK] = undervoltage_lockout_i;
    async_in[SYNC_HOT]  = temp_over_hi_i;
    async_in[SYNC_COOL] = temp_under_lo_i;
  end

  // Two flops each; reset holds the channel in lockout
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= async_in;   // see R15
      sync2_reg <= sync1_reg;  // see R15
    end
  end

  // Only the second stage is ever looked at
  assign lock_s = sync2_reg[SYNC_LOCK];
  assign hot_s  = sync2_reg[SYNC_HOT];
  assign cool_s = sync2_reg[SYNC_COOL];

  // Transmit encoder

  // Edge against last sent level, or refresh once idle too long
  assign tx_edge  = data_i != sent_level_reg;                 // see R1
  assign tx_due   = idle_cnt_reg == RW'(REFRESH_LEN);         // see R3
  assign tx_start = !lock_s && (tx_edge || tx_due);           // see R8

  // Level the far decoder is believed to hold
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sent_level_reg <= LEVEL_DEFAULT;
    end else if (lock_s) begin
      sent_level_reg <= LEVEL_DEFAULT;  // see R10
    end else if (tx_start) begin
      sent_level_reg <= data_i;
    end
  end

  // Idle counter; preset in lockout so a refresh leaves at once on release,
  // which keeps the far output correct well inside the refresh interval
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_reg <= RW'(REFRESH_LEN);
    end else if (lock_s) begin
      idle_cnt_reg <= RW'(REFRESH_LEN);   // see R12
    end else if (tx_start) begin
      idle_cnt_reg <= '0;                 // see R14
    end else begin
      idle_cnt_reg <= idle_cnt_reg + RW'(1);
    end
  end

  // Pulse shaper; type is the new level, so refresh reuses the edge code
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pulse_reg <= '0;
      pw_cnt_reg   <= '0;
    end else if (lock_s) begin
      tx_pulse_reg <= '0;                          // see R8
      pw_cnt_reg   <= '0;
    end else if (tx_start) begin
      tx_pulse_reg.set <= data_i;                  // see R1
      tx_pulse_reg.clr <= !data_i;                 // see R1
      pw_cnt_reg       <= PW'(PULSE_LEN - 1);
    end else if (pw_cnt_reg != '0) begin
      pw_cnt_reg <= pw_cnt_reg - PW'(1);
    end else begin
      tx_pulse_reg <= '0;
    end
  end

  assign tx_pulse_o = tx_pulse_reg;

  // A pulse never carries both codes
  pulse_code_a: assert property (!(tx_pulse_o.set && tx_pulse_o.clr))  // see R1
    else $error("transmit pulse carries set and clear together");

  // An edge yields the matching pulse on the next cycle
  edge_pulse_a: assert property (!lock_s && tx_edge |=>               // see R1
    tx_pulse_o.set == $past(data_i) && tx_pulse_o.clr != $past(data_i))
    else $error("input edge not encoded as matching pulse");

  // Refresh goes out when the idle count is reached
  refresh_due_a: assert property (!lock_s && !tx_edge && tx_due |=>    // see R3
    (tx_pulse_o.set || tx_pulse_o.clr) && idle_cnt_reg == '0)
    else $error("refresh pulse missing after idle interval");

  // Idle counter never passes its terminal count
  refresh_bound_a: assert property (idle_cnt_reg <= RW'(REFRESH_LEN))  // see R14
    else $error("idle counter ran past refresh count");

  // Receive decoder and watchdog

  // Simultaneous set and clear is not a legal code and is ignored
  assign rx_valid   = !lock_s && (rx_pulse_i.set ^ rx_pulse_i.clr);
  assign wd_expired = wd_cnt_reg == WW'(WDOG_LEN);

  // Silence counter saturates at the watchdog count
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_cnt_reg <= '0;
    end else if (lock_s || rx_valid) begin
      wd_cnt_reg <= '0;
    end else if (!wd_expired) begin
      wd_cnt_reg <= wd_cnt_reg + WW'(1);  // see R14
    end
  end

  // Bistable decoder; holds between pulses until the watchdog gives up
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dec_reg <= LEVEL_DEFAULT;
    end else if (lock_s) begin
      dec_reg <= LEVEL_DEFAULT;          // see R11
    end else if (rx_valid) begin
      dec_reg <= rx_pulse_i.set;         // see R2
    end else if (wd_expired) begin
      dec_reg <= LEVEL_DEFAULT;          // see R4
    end
  end

  // Output enable follows lockout so no undefined level reaches the pin
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_reg <= 1'h0;
    end else begin
      oe_reg <= !lock_s;                 // see R9
    end
  end

  assign pad_o.level = dec_reg;
  assign pad_o.oe    = oe_reg;

  // A set or clear pulse lands on the output next cycle
  rx_decode_a: assert property (rx_valid |=> pad_o.level == $past(rx_pulse_i.set))  // see R2
    else $error("decoder did not follow received pulse");

  // Without pulses or timeout the level holds
  rx_hold_a: assert property (!lock_s && !rx_valid && !wd_expired |=>   // see R13
    $stable(pad_o.level))
    else $error("decoder level changed without a pulse");

  // Watchdog forces default level after the silence count
  wdog_fire_a: assert property (!lock_s && !rx_valid && wd_expired |=>  // see R4
    pad_o.level == LEVEL_DEFAULT)
    else $error("watchdog did not force default level");

  // Silence counter saturates rather than wrapping
  wdog_bound_a: assert property (wd_cnt_reg <= WW'(WDOG_LEN))  // see R14
    else $error("silence counter ran past watchdog count");

  // Outside lockout the pad is driven
  oe_follow_a: assert property (!lock_s |=> pad_o.oe)  // see R9
    else $error("pad not driven outside lockout");

  // Lockout puts the pad in high impedance
  lock_hiz_a: assert property (lock_s |=> !pad_o.oe && !pad_o.level)   // see R9
    else $error("output driven during lockout");

  // Release drives the default low level; a pulse in that very cycle may win
  release_low_a: assert property ($fell(lock_s) && !rx_valid |=> pad_o.oe &&  // see R11
    pad_o.level == LEVEL_DEFAULT)
    else $error("output not low on lockout release");

  // Converter power control

  // Thermal latch: over-temperature wins if both indications show at once
  assign pwm_off_next = hot_s || (pwm_off_reg && !cool_s);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_off_reg <= 1'h0;
    end else begin
      pwm_off_reg <= pwm_off_next;       // see R5
    end
  end

  // Oscillator gated by lockout; PWM gated by lockout and the thermal latch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_en_reg <= 1'h0;
      pwm_en_reg <= 1'h0;
    end else begin
      osc_en_reg <= !lock_s;                   // see R7
      pwm_en_reg <= !lock_s && !pwm_off_next;  // see R6
    end
  end

  assign osc_en_o = osc_en_reg;
  assign pwm_en_o = pwm_en_reg;

  // Over-temperature removes the PWM drive next cycle
  thermal_off_a: assert property (hot_s |=> !pwm_en_o)  // see R5
    else $error("PWM still on during over-temperature");

  // Once off, PWM stays off until the cool indication
  thermal_hyst_a: assert property (pwm_off_reg && !cool_s |=> !pwm_en_o)  // see R6
    else $error("PWM resumed before cooling below low threshold");

  // Lockout stops oscillator and transmit pulses
  lock_idle_a: assert property (lock_s |=> !osc_en_o && !pwm_en_o &&      // see R7
    !tx_pulse_o.set && !tx_pulse_o.clr)
    else $error("converter or encoder active during lockout");

  // Outside lockout the oscillator runs
  osc_run_a: assert property (!lock_s |=> osc_en_o)  // see R7
    else $error("oscillator idle outside lockout");

  // Main scenarios
  edge_seen_c: cover property (!lock_s && tx_edge ##1 tx_pulse_o.set);
  refresh_seen_c: cover property (!lock_s && !tx_edge && tx_due);
  wdog_seen_c: cover property (pad_o.level ##1 wd_expired ##1 !pad_o.level);
  thermal_cycle_c: cover property (hot_s ##1 !pwm_en_o ##[1:50] pwm_en_o);
  release_c: cover property ($fell(lock_s) ##[1:200] rx_valid);

endmodule

// >>> testbench/icpc_peer.sv
// Peer channel half across the barrier: pulse encoder and bistable decoder
`timescale 1ns/1ps

module icpc_peer
  import icpc_pkg::*;
#(
  parameter int unsigned REFRESH_LEN = 8
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Peer power and data input
  input  wire logic        powered_i,
  input  wire logic        data_i,
  output icpc_pulse_t      pulse_o,
  // Pulses from the block and decoded level
  input  wire icpc_pulse_t pulse_i,
  output logic             level_o
);
  logic       sent_reg;
  logic [7:0] idle_reg;

  // Encoder; unpowered it is silent and arms an immediate refresh
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_o  <= '0;
      sent_reg <= LEVEL_DEFAULT;
      idle_reg <= 8'(REFRESH_LEN);
    end else if (!powered_i) begin
      pulse_o  <= '0;
      sent_reg <= LEVEL_DEFAULT;
      idle_reg <= 8'(REFRESH_LEN);
    end else if (data_i != sent_reg || idle_reg == 8'(REFRESH_LEN)) begin
      pulse_o  <= {data_i, !data_i};
      sent_reg <= data_i;
      idle_reg <= 8'h00;
    end else begin
      pulse_o  <= '0;
      idle_reg <= idle_reg + 8'h01;
    end
  end

  // Decoder holds its level between pulses
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= LEVEL_DEFAULT;
    end else if (pulse_i.set ^ pulse_i.clr) begin
      level_o <= pulse_i.set;
    end
  end
endmodule

// >>> testbench/icpc_channel_tb.sv
// Self-checking bench for one isolation channel half facing a peer model
`timescale 1ns/1ps

module icpc_channel_tb;
  import icpc_pkg::*;
  // Short counts keep the run brief
  localparam int unsigned REF_LEN = 8;
  localparam int unsigned WD_LEN  = 20;
  logic        mclk_i    = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        lockout   = 1'b0;
  logic        hot       = 1'b0;
  logic        cool      = 1'b0;
  logic        data      = 1'b0;
  logic        peer_on   = 1'b0;
  logic        peer_data = 1'b1;
  logic        osc;
  logic        pwm;
  logic        peer_level;
  icpc_pulse_t tx;
  icpc_pulse_t rx;
  icpc_pad_t   pad;
  int          bad_count   = 0;
  int          comparisons = 0;

  always #4 mclk_i = ~mclk_i;

  icpc_channel #(.PULSE_LEN(1), .REFRESH_LEN(REF_LEN), .WDOG_LEN(WD_LEN)) u_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .undervoltage_lockout_i(lockout),
    .temp_over_hi_i(hot), .temp_under_lo_i(cool), .data_i(data), .tx_pulse_o(tx),
    .rx_pulse_i(rx), .pad_o(pad), .osc_en_o(osc), .pwm_en_o(pwm));

  icpc_peer #(.REFRESH_LEN(REF_LEN)) u_peer (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .powered_i(peer_on), .data_i(peer_data),
    .pulse_o(rx), .pulse_i(tx), .level_o(peer_level));

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask

  // Pass n edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic give_up;
    bad_count++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask

  // Edges until the next transmitted pulse
  task automatic wait_tx(output int n);
    n = 1;
    tick(1);
    while (tx === 2'b00 && n < 40) begin
      tick(1);
      n++;
    end
    if (tx === 2'b00) give_up();
  endtask

  task automatic wait_level(input logic v);
    int n;
    n = 0;
    while (pad.level !== v && n < int'(REF_LEN) + 4) begin
      tick(1);
      n++;
    end
    if (pad.level !== v) give_up();
  endtask

  task automatic test_startup;
    check(pad, 2'b00);
    check({osc, pwm}, 2'b00);
    rst_b_i <= 1'b1;
    tick(2);
    check({osc, pwm}, 2'b00);
    tick(1);
    check({osc, pwm}, 2'b11);
    check(pad, 2'b01);
    check(tx, 2'b01);
    peer_on <= 1'b1;
    wait_level(1'b1);
    $display("test_startup done");
  endtask

  task automatic test_edges;
    @(posedge mclk_i);
    data <= 1'b1;
    tick(1);
    check(tx, 2'b10);
    @(posedge mclk_i);
    data <= 1'b0;
    tick(1);
    check(tx, 2'b01);
    tick(1);
    check(tx, 2'b00);
    $display("test_edges done");
  endtask

  task automatic test_refresh;
    int n;
    @(posedge mclk_i);
    data <= 1'b1;
    wait_tx(n);
    wait_tx(n);
    check({1'b0, n == int'(REF_LEN) + 1}, 2'b01);
    check(tx, 2'b10);
    tick(1);
    check({1'b0, peer_level}, 2'b01);
    $display("test_refresh done");
  endtask

  task automatic test_decode;
    @(posedge mclk_i);
    peer_data <= 1'b0;
    tick(1);
    check(pad, 2'b11);
    tick(1);
    check(pad, 2'b01);
    @(posedge mclk_i);
    peer_data <= 1'b1;
    tick(2);
    check(pad, 2'b11);
    $display("test_decode done");
  endtask

  task automatic test_watchdog;
    @(posedge mclk_i);
    peer_data <= 1'b0;
    tick(2);
    @(posedge mclk_i);
    peer_data <= 1'b1;
    @(posedge mclk_i);
    peer_on <= 1'b0;
    tick(1);
    check(pad, 2'b11);
    tick(WD_LEN);
    check(pad, 2'b11);
    tick(1);
    check(pad, 2'b01);
    $display("test_watchdog done");
  endtask

  task automatic test_lockout;
    @(posedge mclk_i);
    lockout <= 1'b1;
    tick(2);
    check({osc, pwm}, 2'b11);
    tick(1);
    check({osc, pwm}, 2'b00);
    check(pad, 2'b00);
    repeat (4) begin
      @(posedge mclk_i);
      data <= ~data;
      tick(1);
      check(tx, 2'b00);
    end
    @(posedge mclk_i);
    lockout <= 1'b0;
    tick(3);
    check(pad, 2'b01);
    check(tx, {data, ~data});
    peer_on <= 1'b1;
    wait_level(1'b1);
    $display("test_lockout done");
  endtask

  task automatic test_thermal;
    @(posedge mclk_i);
    hot <= 1'b1;
    tick(2);
    check({osc, pwm}, 2'b11);
    tick(1);
    check({osc, pwm}, 2'b10);
    @(posedge mclk_i);
    hot <= 1'b0;
    tick(6);
    check({osc, pwm}, 2'b10);
    @(posedge mclk_i);
    cool <= 1'b1;
    tick(3);
    check({osc, pwm}, 2'b11);
    @(posedge mclk_i);
    cool <= 1'b0;
    tick(3);
    check({osc, pwm}, 2'b11);
    $display("test_thermal done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    test_startup();
    test_edges();
    test_refresh();
    test_decode();
    test_watchdog();
    test_lockout();
    test_thermal();
    stop_test();
  end
endmodule
